/* File: conv_ctrl.sv */
// converter control: enable, input mux select, gain, coding, APB registers
// assumes APB master on ref_clk and digitised front-end level on sample_level
//
// Operation
// - converter runs only while converter_enable is 1
// - enable 0 holds shutdown, no conversions
// - 8-bit SAR with track-hold, up to 500 ksps, via amplifier
// - input_mux has 11 sources over positive and negative sides
// - negative side picks any pin or ground
// - temperature sensor and supply only on positive side
// - mux selections come from input_select_reg fields
// - negative select ground means single-ended mode
// - any other negative select means differential mode
// - single-ended result is unsigned 0x00 to 0xff
// - single-ended span zero to reference times 255/256
// - differential result is two's complement, 0x80 at minus reference
// - differential span minus reference to reference times 127/128
// - amp_gain_field two bits select gain 0.5, 1, 2 or 4
// - gain resets to 0.5
// - negative field bits 7:4, 0xxx pins, 1xxx ground
// - positive field bits 3:0, pins, 1000 temp, 1001 supply
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module conv_ctrl
  import conv_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] sample_level,
  output logic powered,
  output logic [7:0] pos_pin_sel,
  output logic pos_temp_sel,
  output logic pos_supply_sel,
  output logic [7:0] neg_pin_sel,
  output logic neg_ground_sel,
  output logic [1:0] amp_gain,
  output logic tracking
);
  typedef enum logic [1:0] {idle, track, convert} conv_state_e;

  // ****************************************
  // decode helpers
  // ****************************************
  // one-hot pin decode used for both mux sides
  function automatic logic [7:0] pin_onehot(input logic [3:0] code);
    logic [7:0] hot;
    hot = 8'h00;
    if (!code[3]) begin
      hot[code[2:0]] = 1'b1;
    end
    return hot;
  endfunction

  // register access decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  // ****************************************
  // registers
  // ****************************************
  logic converter_enable;
  logic [7:0] input_select_reg;
  logic [1:0] amp_gain_field;
  logic [7:0] result;
  logic done;
  logic start_req;
  conv_state_e state;
  logic [3:0] step;
  logic [3:0] bit_idx;
  logic [7:0] trial;
  logic wr;
  logic rd;
  logic mapped;
  logic [3:0] negative_select_field;
  logic [3:0] positive_select_field;
  logic differential;
  logic step_tick;
  logic [31:0] next_prdata;
  sample_if link_s ();

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign negative_select_field = input_select_reg[neg_lsb +: 4];
  assign positive_select_field = input_select_reg[pos_lsb +: 4];
  // ground on negative side is single-ended, anything else differential
  assign differential = !negative_select_field[3];
  assign mapped = hit(paddr, ctrl_addr) || hit(paddr, select_addr)
    || hit(paddr, config_addr) || hit(paddr, result_addr)
    || hit(paddr, status_addr);
  assign step_tick = step == step_count - 4'h1;

  // ****************************************
  // control register
  // ****************************************
  // enable bit gates the sequencer, powered and tracking; mux selects and gain stay driven
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      converter_enable <= 1'b0;
    end else if (wr && hit(paddr, ctrl_addr)) begin
      converter_enable <= pwdata[enable_bit];
    end
  end

  // start only counts when the same write leaves the block enabled, so
  // enable and start may share one write; a start while off is dropped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      start_req <= 1'b0;
    end else if (wr && hit(paddr, ctrl_addr) && pwdata[start_bit]
                 && pwdata[enable_bit] && state == idle) begin
      start_req <= 1'b1;
    end else if (!converter_enable) begin
      start_req <= 1'b0;
    end else if (state == track) begin
      start_req <= 1'b0;
    end
  end

  // ****************************************
  // select and config registers
  // ****************************************
  // both mux fields are software-written
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      input_select_reg <= select_reset;
    end else if (wr && hit(paddr, select_addr)) begin
      input_select_reg <= pwdata[7:0];
    end
  end

  // gain field, 0.5 after reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      amp_gain_field <= gain_half;
    end else if (wr && hit(paddr, config_addr)) begin
      amp_gain_field <= pwdata[gain_lsb +: 2];
    end
  end

  // ****************************************
  // analog front-end controls
  // ****************************************
  // registered mux selects; reserved positive codes select nothing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pos_pin_sel <= 8'h00;
      pos_temp_sel <= 1'b0;
      pos_supply_sel <= 1'b0;
      neg_pin_sel <= 8'h00;
      neg_ground_sel <= 1'b0;
      amp_gain <= gain_half;
      powered <= 1'b0;
    end else begin
      pos_pin_sel <= pin_onehot(positive_select_field);
      pos_temp_sel <= positive_select_field == pos_temp;
      pos_supply_sel <= positive_select_field == pos_supply;
      neg_pin_sel <= pin_onehot(negative_select_field);
      neg_ground_sel <= negative_select_field[3];
      amp_gain <= amp_gain_field;
      powered <= converter_enable;
    end
  end

  // ****************************************
  // successive approximation
  // ****************************************
  // step timer paces eight-cycle steps, nine per conversion (track plus eight bits), 72 cycles in all
  always_ff @(posedge ref_clk) begin
    if (rst || state == idle) begin
      step <= 4'h0;
    end else if (step_tick) begin
      step <= 4'h0;
    end else begin
      step <= step + 4'h1;
    end
  end

  // sar sequencer; leaving enable aborts at once to shutdown
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= idle;
    end else if (!converter_enable) begin
      state <= idle;
    end else begin
      case (state)
        idle: begin
          if (start_req) begin
            state <= track;
          end
        end
        track: begin
          if (step_tick) begin
            state <= convert;
          end
        end
        convert: begin
          if (step_tick && bit_idx == 4'h0) begin
            state <= idle;
          end
        end
        default: begin
          state <= idle;
        end
      endcase
    end
  end

  // bit pointer walks from the msb down, one bit per step
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bit_idx <= 4'h0;
    end else if (state == track && step_tick) begin
      bit_idx <= 4'(sar_bits - 1);
    end else if (state == convert && step_tick && bit_idx != 4'h0) begin
      bit_idx <= bit_idx - 4'h1;
    end
  end

  // trial code; a bit stays set only if the level reaches it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trial <= 8'h00;
    end else if (state == track && step_tick) begin
      trial <= 8'h00;
      trial[sar_bits - 1] <= 1'b1;
    end else if (state == convert && step_tick) begin
      // answer for the current trial is settled by now
      if (!link_s.above) begin
        trial[bit_idx[2:0]] <= 1'b0;
      end
      if (bit_idx != 4'h0) begin
        trial[bit_idx[2:0] - 3'h1] <= 1'b1;
      end
    end
  end

  // trial is coded in the live mode so the comparator offsets it
  assign link_s.trial = differential ? (trial ^ diff_min) : trial;
  assign link_s.differential = differential;

  // ****************************************
  // result and done flag
  // ****************************************
  // result holds until a new conversion ends, even through shutdown
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result <= se_zero;
    end else if (converter_enable && state == convert && step_tick
                 && bit_idx == 4'h0) begin
      // unsigned when single-ended, two's complement when differential
      result <= differential
        ? ({trial[7:1], trial[0] & link_s.above} ^ diff_min)
        : {trial[7:1], trial[0] & link_s.above};
    end
  end

  // done set by completion wins over a software clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done <= 1'b0;
    end else if (converter_enable && state == convert && step_tick
                 && bit_idx == 4'h0) begin
      done <= 1'b1;
    end else if (wr && hit(paddr, status_addr) && pwdata[done_bit]) begin
      done <= 1'b0;
    end
  end

  // track output for the hold switch
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tracking <= 1'b0;
    end else begin
      tracking <= converter_enable && state != convert;
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  // word of the addressed register; unused bits and holes read zero
  always_comb begin
    next_prdata = 32'h00000000;
    case (paddr)
      ctrl_addr: begin
        next_prdata[enable_bit] = converter_enable;
      end
      select_addr: begin
        next_prdata[7:0] = input_select_reg;
      end
      config_addr: begin
        next_prdata[gain_lsb +: 2] = amp_gain_field;
      end
      result_addr: begin
        next_prdata[7:0] = result;
      end
      status_addr: begin
        next_prdata[busy_bit] = state != idle;
        next_prdata[diff_bit] = differential;
        next_prdata[done_bit] = done;
      end
      default: begin
        next_prdata = 32'h00000000;
      end
    endcase
  end

  // ****************************************
  // apb slave
  // ****************************************
  // zero wait: read data captured in setup, ready in access
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rd) begin
        prdata <= next_prdata;
      end
    end
  end

  // ****************************************
  // comparator helper
  // ****************************************
  sample_compare compare_u (
    .ref_clk(ref_clk),
    .rst(rst),
    .level(sample_level),
    .port_s(link_s)
  );
endmodule // conv_ctrl

/* File: conv_ctrl_sva.sv */
// port checker for the converter control block
// assumes a bind onto conv_ctrl, one clock and a synchronous reset
`timescale 1ns/1ps
module conv_ctrl_sva
  import conv_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic powered,
  input wire logic [7:0] pos_pin_sel,
  input wire logic pos_temp_sel,
  input wire logic pos_supply_sel,
  input wire logic [7:0] neg_pin_sel,
  input wire logic neg_ground_sel,
  input wire logic [1:0] amp_gain,
  input wire logic tracking
);
  // ******
  // bus, reset, shutdown, selection and gain checks
  // ******
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic wr;
  // write phase qualifier, shared by the select and gain checks
  assign wr = psel && penable && pwrite;
  reset_quiet_a: assert property (disable iff (1'b0)
    rst |=> !pready && !powered && amp_gain == gain_half)
    else $error("reset left outputs active");
  ready_wait_a: assert property (psel && !penable |=> pready)
    else $error("no zero wait answer");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  error_pair_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  shut_idle_a: assert property (!powered [*2] |-> !tracking)
    else $error("tracking while shut down");
  neg_decode_a: assert property (!$past(rst) |->
    $onehot({neg_pin_sel, neg_ground_sel}))
    else $error("negative select not one-hot");
  pos_decode_a: assert property ($onehot0({pos_pin_sel,
    pos_temp_sel, pos_supply_sel}))
    else $error("positive select overlaps");
  ground_mode_a: assert property (wr && paddr == select_addr
    && pwdata[7] |-> ##[1:2] neg_ground_sel)
    else $error("ground code not applied");
  temp_pick_a: assert property (wr && paddr == select_addr
    && pwdata[3:0] == pos_temp |-> ##[1:2] pos_temp_sel)
    else $error("sensor code not applied");
  gain_set_a: assert property (wr && paddr == config_addr
    && pwdata[1:0] == gain_four |-> ##[1:2] amp_gain == gain_four)
    else $error("gain code not applied");
endmodule // conv_ctrl_sva

bind conv_ctrl conv_ctrl_sva u_sva (.ref_clk, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .powered, .pos_pin_sel,
  .pos_temp_sel, .pos_supply_sel, .neg_pin_sel, .neg_ground_sel,
  .amp_gain, .tracking);

/* File: conv_pkg.sv */
// constants shared by the converter control block and its sample helper
// assumes a 32-bit APB master and one 40 MHz clock
package conv_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] select_addr = 8'h04;
  localparam logic [7:0] config_addr = 8'h08;
  localparam logic [7:0] result_addr = 8'h0c;
  localparam logic [7:0] status_addr = 8'h10;
  // ****************************************
  // fields
  // ****************************************
  localparam int enable_bit = 0;
  localparam int start_bit = 1;
  localparam int diff_bit = 1;
  localparam int busy_bit = 0;
  localparam int done_bit = 2;
  localparam int gain_lsb = 0;
  localparam int neg_lsb = 4;
  localparam int pos_lsb = 0;
  localparam logic [7:0] select_reset = 8'h00;
  localparam logic [1:0] gain_half = 2'h0;
  localparam logic [1:0] gain_one = 2'h1;
  localparam logic [1:0] gain_two = 2'h2;
  localparam logic [1:0] gain_four = 2'h3;
  // ****************************************
  // input codes
  // ****************************************
  localparam logic [3:0] pos_temp = 4'h8;
  localparam logic [3:0] pos_supply = 4'h9;
  localparam int sources_total = 11;
  localparam int pin_count = 8;
  // ****************************************
  // timing: 500 ksps at most, 8 bits
  // ****************************************
  localparam int clk_hz = 40000000;
  localparam int max_sps = 500000;
  localparam int conv_cycles = clk_hz / max_sps;
  localparam int sar_bits = 8;
  localparam int step_cycles = conv_cycles / (sar_bits + 2);
  localparam logic [3:0] step_count = 4'(step_cycles);
  localparam logic [7:0] se_zero = 8'h00;
  localparam logic [7:0] diff_min = 8'h80;
endpackage

/* File: front_end.sv */
// analog front end model: pins, sensor and supply digitised to a level
// assumes pins already set analog and skipped by the crossbar
`timescale 1ns/1ps
module front_end
  import conv_pkg::*;
#(
  parameter logic [7:0] temp_level = 8'h5a
)
(
  input wire logic ref_clk,
  input wire logic powered,
  input wire logic [7:0] pin_v [8],
  input wire logic [7:0] pos_pin_sel,
  input wire logic pos_temp_sel,
  input wire logic [7:0] neg_pin_sel,
  input wire logic neg_ground_sel,
  output logic [7:0] sample_level
);
  logic [7:0] vp;
  logic [7:0] vn;
  logic [8:0] d;
  logic [7:0] junk = 8'h00;
  // source pick; supply reads full scale, sensor only positive
  always_comb begin
    vp = pos_temp_sel ? temp_level : 8'hff;
    vn = 8'h00;
    for (int i = 0; i < pin_count; i++) begin
      if (pos_pin_sel[i]) vp = pin_v[i];
      if (neg_pin_sel[i]) vn = pin_v[i];
    end
    d = {1'b0, vp} - {1'b0, vn};
  end
  // changing garbage while off so a stale level never matches
  always_ff @(posedge ref_clk) junk <= junk + 8'h37;
  assign sample_level = !powered ? junk : neg_ground_sel ? vp :
    d[8:1] + 8'h80;
endmodule // front_end

/* File: sample_compare.sv */
// compares a SAR trial code with the sampled analog level
// assumes the sampled level is an unsigned 8-bit quantity from the front end
`timescale 1ns/1ps
module sample_compare
  import conv_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] level,
  sample_if.helper port_s
);
  // ****************************************
  // comparator
  // ****************************************
  // in differential mode trial is two's complement; flip msb to compare
  logic [7:0] biased;
  assign biased = port_s.differential ? (port_s.trial ^ diff_min)
                                      : port_s.trial;
  // registered so the answer is clean one cycle after the trial
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      port_s.above <= 1'b0;
    end else begin
      port_s.above <= level >= biased;
    end
  end
endmodule // sample_compare

/* File: sample_if.sv */
// carries comparator query and answer between control and sample helper
// assumes one clock domain
`timescale 1ns/1ps
interface sample_if;
  logic [7:0] trial;
  logic differential;
  logic above;
  modport ctrl (output trial, output differential, input above);
  modport helper (input trial, input differential, output above);
endinterface

/* File: tb.sv */
// self-checking bench for conv_ctrl over APB with a front end model
// assumes conv_pkg, conv_ctrl and front_end are compiled first
`timescale 1ns/1ps
`define chk(n, e, g) begin checks++; if ((g) !== (e)) begin \
  mismatches++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module tb;
  import conv_pkg::*;
  localparam logic [7:0] temp_v = 8'h5a;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic pready, pslverr, powered, pos_temp_sel, pos_supply_sel;
  logic neg_ground_sel, tracking;
  logic [7:0] pos_pin_sel, neg_pin_sel, sample_level;
  logic [1:0] amp_gain;
  logic [7:0] pin_v [8] = '{default: 8'h00};
  int mismatches = 0, checks = 0;
  initial forever #12.5 ref_clk = ~ref_clk;
  conv_ctrl u_dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sample_level, .powered,
    .pos_pin_sel, .pos_temp_sel, .pos_supply_sel, .neg_pin_sel,
    .neg_ground_sel, .amp_gain, .tracking);
  front_end #(.temp_level(temp_v)) u_fe (.ref_clk, .powered, .pin_v,
    .pos_pin_sel, .pos_temp_sel, .neg_pin_sel, .neg_ground_sel,
    .sample_level);
  // ******
  // bus tasks
  // ******
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // the slave sets the pace; only the count limits a hang
    do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 40);
    `chk("pready", 1'b1, pready) // a lost answer counts as a mismatch
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
    input string nm);
    apb(1'b0, a, 32'h0);
    `chk(nm, e, rd)
  endtask
  task automatic conv(input logic [7:0] sel, input logic [7:0] e,
    input logic dm);
    int n;
    n = 0;
    apb(1'b1, select_addr, {24'h0, sel});
    apb(1'b1, ctrl_addr, 32'h3);
    do begin apb(1'b0, status_addr, 32'h0); n++; end
      while (rd[done_bit] !== 1'b1 && n < 100);
    `chk("done", 1'b1, rd[done_bit])
    `chk("powered", 1'b1, powered)
    `chk("mode", dm, rd[diff_bit])
    rd_chk(result_addr, {24'h0, e}, "result");
    apb(1'b1, status_addr, 32'h4);
  endtask
  task automatic complete_run;
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ******
  // scenarios
  // ******
  task automatic t_reset;
    rd_chk(select_addr, 32'h0, "select");
    rd_chk(config_addr, 32'h0, "gain reg");
    `chk("gain pin", gain_half, amp_gain)
    `chk("powered", 1'b0, powered)
    apb(1'b0, 8'h40, 32'h0);
    `chk("unmapped", 1'b1, err)
  endtask
  // both fields walk every code, reserved and ground aliases included
  task automatic t_select;
    for (int p = 0; p < 16; p++) begin
      apb(1'b1, select_addr, 32'(p * 17));
      repeat (2) @(posedge ref_clk);
      `chk("pos pin", p < 8 ? 8'h1 << p : 8'h0, pos_pin_sel)
      `chk("temp", 1'(p == 8), pos_temp_sel)
      `chk("supply", 1'(p == 9), pos_supply_sel)
      `chk("neg pin", p < 8 ? 8'h1 << p : 8'h0, neg_pin_sel)
      `chk("ground", 1'(p > 7), neg_ground_sel)
      rd_chk(select_addr, 32'(p * 17), "select reg");
    end
  endtask
  task automatic t_gain;
    for (int g = 0; g < 4; g++) begin
      apb(1'b1, config_addr, 32'(g));
      rd_chk(config_addr, 32'(g), "gain reg");
      `chk("gain pin", 2'(g), amp_gain)
    end
  endtask
  task automatic t_code;
    pin_v <= '{8'h00, 8'h40, 8'h80, 8'hff, 8'hc0, 8'h01, 8'h7f, 8'h20};
    conv(8'h80, 8'h00, 1'b0);
    conv(8'hf3, 8'hff, 1'b0);
    conv(8'h82, 8'h80, 1'b0);
    conv(8'h81, 8'h40, 1'b0);
    conv(8'h88, temp_v, 1'b0);
    conv(8'h03, 8'h7f, 1'b1);
    conv(8'h30, 8'h80, 1'b1);
    conv(8'h20, 8'hc0, 1'b1);
    conv(8'h72, 8'h30, 1'b1);
  endtask
  // abort mid-conversion, then a start while off must change nothing
  task automatic t_shutdown;
    apb(1'b1, select_addr, 32'h80);
    apb(1'b1, ctrl_addr, 32'h3);
    repeat (20) @(posedge ref_clk);
    apb(1'b1, ctrl_addr, 32'h0);
    apb(1'b1, ctrl_addr, 32'h2);
    repeat (100) @(posedge ref_clk);
    `chk("powered", 1'b0, powered)
    `chk("tracking", 1'b0, tracking)
    apb(1'b0, status_addr, 32'h0);
    `chk("busy", 1'b0, rd[busy_bit])
    `chk("done", 1'b0, rd[done_bit])
    rd_chk(result_addr, 32'h30, "kept result");
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset;
    t_select;
    t_gain;
    t_code;
    t_shutdown;
    complete_run;
  end
  // watchdog well beyond the thousand or so cycles the run needs
  initial begin
    repeat (30000) @(posedge ref_clk);
    mismatches++;
    complete_run;
  end
endmodule // tb
